/* rtl/atc_pkg.sv */
package atc_pkg;
   localparam int unsigned CLK_PERIOD_NS      = 5;
   localparam int unsigned HOLD_DELAY_NS      = 100;
   localparam int unsigned DAC_UPD_DELAY_NS   = 100;
   localparam int unsigned SYNC_LAT_CYC       = 3;
   localparam int unsigned HOLD_DELAY_CYC     = HOLD_DELAY_NS / CLK_PERIOD_NS;
   localparam int unsigned DAC_UPD_DELAY_CYC  = DAC_UPD_DELAY_NS
                                                / CLK_PERIOD_NS;

   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned CNT_W  = 16;

   localparam logic [ADDR_W-1:0] OFS_CTRL     = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_SAMPLES  = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_INTERVAL = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_REMAIN   = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_CMD      = 4'h5;

   localparam int unsigned CTL_EXT_CONV   = 0;
   localparam int unsigned CTL_PRETRIG    = 1;
   localparam int unsigned CTL_TRIG_BLOCK = 2;
   localparam int unsigned CTL_SW_GATE    = 3;
   localparam int unsigned CTL_UPD_SRC    = 4;
   localparam int unsigned CTL_WAVE_MODE  = 5;
   localparam int unsigned CTL_BITS       = 6;
   localparam logic [CTL_BITS-1:0] CTRL_RST = 6'h08;

   localparam int unsigned CMD_START = 0;
   localparam int unsigned CMD_ABORT = 1;

   localparam logic [CNT_W-1:0] SAMPLES_RST  = 16'h0010;
   localparam logic [CNT_W-1:0] INTERVAL_RST = 16'h00C8;
   localparam logic [CNT_W-1:0] CNT_ONE      = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_ZERO     = 16'h0000;
   localparam logic [DATA_W-1:0] DATA_ZERO   = 16'h0000;

   localparam int unsigned N_SYNC    = 4;
   localparam int unsigned SYN_CONV  = 0;
   localparam int unsigned SYN_TRIG  = 1;
   localparam int unsigned SYN_GATE  = 2;
   localparam int unsigned SYN_DAC   = 3;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_PRE   = 4'b0010,
      ST_POST  = 4'b0100,
      ST_DONE  = 4'b1000
   } atc_state_type;
endpackage

/* rtl/atc_sync_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface atc_sync_if;
   import atc_pkg::*;
   logic [N_SYNC-1:0] raw;
   logic [N_SYNC-1:0] level;
   logic [N_SYNC-1:0] fall;
   modport src (output raw, input level, input fall);
   modport syn (input raw, output level, output fall);
endinterface
`default_nettype wire

/* rtl/atc_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module atc_sync (
   input  wire logic     i_clock,
   input  wire logic     i_rst,
   atc_sync_if.syn       sif
);
   import atc_pkg::*;

   typedef struct packed {
      logic [N_SYNC-1:0] meta;
      logic [N_SYNC-1:0] stab;
      logic [N_SYNC-1:0] prev;
   } atc_sync_st_type;

   atc_sync_st_type st_r;
   atc_sync_st_type st_nxt;

   // all inputs idle high, so reset loads ones and no false edge appears
   always_comb begin
      st_nxt      = st_r;
      st_nxt.meta = sif.raw;
      st_nxt.stab = st_r.meta;
      st_nxt.prev = st_r.stab;
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_r <= '1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sif.level = st_r.stab;
   assign sif.fall  = st_r.prev & ~st_r.stab;
endmodule
`default_nettype wire

/* rtl/atc_trigger_ctrl.sv */
// How it works
// - low pulse on convert pin starts conversion
// - hold strobe at fixed delay under 100ns
// - counter drives pin only in internal mode
// - conversions blocked outside sequence or gated
// - trigger falling edge starts both counters
// - pretrigger: second edge enables sample countdown
// - first conversion within one sample interval
// - internal start ANDed with trigger pin
// - control bit blocks external trigger
// - gate pin low blocks all conversions
// - update pin edge updates dac if enabled
// - dac update strobe within 100ns
`timescale 1ns/100ps
`default_nettype none
module atc_trigger_ctrl (
   input  wire logic                  i_clock,
   input  wire logic                  i_rst,
   input  wire logic [atc_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [atc_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   output logic [atc_pkg::DATA_W-1:0] o_rdata,
   input  wire logic                  i_ext_convert_n,
   output logic                       o_ext_convert_n,
   output logic                       o_ext_convert_n_oe,
   input  wire logic                  i_ext_acq_trigger_n,
   input  wire logic                  i_ext_convert_gate_n,
   input  wire logic                  i_ext_dac_update_n,
   output logic                       o_adc_hold,
   output logic                       o_dac_update,
   output logic                       o_acq_active,
   output logic                       o_acq_done
);
   import atc_pkg::*;

   typedef struct packed {
      atc_state_type          state;
      logic [CTL_BITS-1:0]    ctrl;
      logic [CNT_W-1:0]       samples;
      logic [CNT_W-1:0]       interval;
      logic [CNT_W-1:0]       remain;
      logic [CNT_W-1:0]       tick;
      logic                   counting;
      logic                   cnt_out;
      logic                   hold;
      logic                   dac_upd;
      logic [DATA_W-1:0]      rdata;
   } atc_top_st_type;

   atc_top_st_type st_r;
   atc_top_st_type st_nxt;

   atc_sync_if sif ();

   atc_sync u_sync (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .sif     (sif)
   );

   // the pin readback carries the counter's own drive in internal mode
   assign sif.raw[SYN_CONV] = i_ext_convert_n;
   assign sif.raw[SYN_TRIG] = i_ext_acq_trigger_n;
   assign sif.raw[SYN_GATE] = i_ext_convert_gate_n;
   assign sif.raw[SYN_DAC]  = i_ext_dac_update_n;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   // one decode serves the conversion gate and the status output
   function automatic logic in_seq(input atc_state_type s);
      in_seq = (s == ST_PRE) || (s == ST_POST);
   endfunction

   logic active;
   logic ext_mode;
   logic gate_open;
   logic conv_req;
   logic trig_edge;
   logic sw_start;
   logic sw_abort;
   logic tick_wrap;

   always_comb begin
      active    = in_seq(st_r.state);
      ext_mode  = st_r.ctrl[CTL_EXT_CONV];
      // gate pin low or software gate low shuts conversions
      gate_open = sif.level[SYN_GATE] & st_r.ctrl[CTL_SW_GATE];
      tick_wrap = (st_r.tick == CNT_ZERO);
      // trigger edge ignored when blocked by control
      trig_edge = sif.fall[SYN_TRIG] & ~st_r.ctrl[CTL_TRIG_BLOCK];
      sw_start  = i_wr && hit(i_addr, OFS_CMD) && i_wdata[CMD_START];
      sw_abort  = i_wr && hit(i_addr, OFS_CMD) && i_wdata[CMD_ABORT];
      if (ext_mode) begin
         conv_req = sif.fall[SYN_CONV];
      end else begin
         conv_req = st_r.counting && tick_wrap;
      end
      conv_req = conv_req && active && gate_open;
   end

   always_comb begin
      st_nxt         = st_r;
      st_nxt.hold    = 1'b0;
      st_nxt.dac_upd = 1'b0;
      st_nxt.cnt_out = 1'b1;
      st_nxt.rdata   = DATA_ZERO;

      if (i_wr) begin
         if (hit(i_addr, OFS_CTRL)) begin
            st_nxt.ctrl = i_wdata[CTL_BITS-1:0];
         end
         if (hit(i_addr, OFS_SAMPLES)) begin
            st_nxt.samples = i_wdata[CNT_W-1:0];
         end
         if (hit(i_addr, OFS_INTERVAL)) begin
            st_nxt.interval = i_wdata[CNT_W-1:0];
         end
      end

      // interval counter: reloads on wrap so each period is interval+1
      if (st_r.counting) begin
         if (tick_wrap) begin
            st_nxt.tick = st_r.interval;
         end else begin
            st_nxt.tick = st_r.tick - CNT_ONE;
         end
         st_nxt.cnt_out = ~tick_wrap;
      end

      unique case (st_r.state)
         ST_IDLE, ST_DONE: begin
            // internal start needs trigger pin high too
            if ((sw_start && sif.level[SYN_TRIG]) || trig_edge) begin
               st_nxt.state    = st_r.ctrl[CTL_PRETRIG] ? ST_PRE : ST_POST;
               st_nxt.remain   = st_r.samples;
               // first tick fires at once, well inside one interval
               st_nxt.tick     = CNT_ZERO;
               st_nxt.counting = 1'b1;
            end
         end
         ST_PRE: begin
            // data taken but remain not counted down until the second edge
            if (trig_edge) begin
               st_nxt.state = ST_POST;
            end
         end
         ST_POST: begin
            if (conv_req) begin
               st_nxt.remain = st_r.remain - CNT_ONE;
               if (st_r.remain <= CNT_ONE) begin
                  st_nxt.state    = ST_DONE;
                  st_nxt.counting = 1'b0;
               end
            end
         end
      endcase

      if (sw_abort) begin
         st_nxt.state    = ST_IDLE;
         st_nxt.counting = 1'b0;
      end

      // hold strobe has fixed latency from the edge: sync plus one reg
      st_nxt.hold = conv_req;

      // dac update: only external source and waveform mode programmed
      st_nxt.dac_upd = sif.fall[SYN_DAC] && ~st_r.ctrl[CTL_UPD_SRC]
                       && st_r.ctrl[CTL_WAVE_MODE];

      if (i_rd) begin
         if (hit(i_addr, OFS_CTRL)) begin
            st_nxt.rdata = {{(DATA_W-CTL_BITS){1'b0}}, st_r.ctrl};
         end else if (hit(i_addr, OFS_SAMPLES)) begin
            st_nxt.rdata = st_r.samples;
         end else if (hit(i_addr, OFS_INTERVAL)) begin
            st_nxt.rdata = st_r.interval;
         end else if (hit(i_addr, OFS_STATUS)) begin
            st_nxt.rdata = DATA_W'({sif.level, st_r.state});
         end else if (hit(i_addr, OFS_REMAIN)) begin
            st_nxt.rdata = st_r.remain;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_r.state    <= ST_IDLE;
         st_r.ctrl     <= CTRL_RST;
         st_r.samples  <= SAMPLES_RST;
         st_r.interval <= INTERVAL_RST;
         st_r.remain   <= CNT_ZERO;
         st_r.tick     <= CNT_ZERO;
         st_r.counting <= 1'b0;
         st_r.cnt_out  <= 1'b1;
         st_r.hold     <= 1'b0;
         st_r.dac_upd  <= 1'b0;
         st_r.rdata    <= DATA_ZERO;
      end else begin
         st_r <= st_nxt;
      end
   end

   // counter drives the shared pin whenever CTL_EXT_CONV is clear, pacing or not; else released
   assign o_ext_convert_n    = st_r.cnt_out;
   assign o_ext_convert_n_oe = ~st_r.ctrl[CTL_EXT_CONV];
   assign o_adc_hold         = st_r.hold;
   assign o_dac_update       = st_r.dac_upd;
   assign o_acq_active       = in_seq(st_r.state);
   assign o_acq_done         = (st_r.state == ST_DONE);
   assign o_rdata            = st_r.rdata;
endmodule
`default_nettype wire

/* verification/atc_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module atc_monitor (
   input wire logic                       i_clock,
   input wire logic                       i_rst,
   input wire logic [atc_pkg::ADDR_W-1:0] i_addr,
   input wire logic [atc_pkg::DATA_W-1:0] i_wdata,
   input wire logic                       i_wr,
   input wire logic                       i_ext_convert_n,
   input wire logic                       o_ext_convert_n_oe,
   input wire logic                       i_ext_convert_gate_n,
   input wire logic                       i_ext_dac_update_n,
   input wire logic                       o_adc_hold,
   input wire logic                       o_dac_update,
   input wire logic                       o_acq_active,
   input wire logic                       o_acq_done
);
   import atc_pkg::*;
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);
   // pin fall first sampled three edges before the pulse: two sync
   // stages and the output register, so the delay never varies
   sequence conv_fell_before;
      !$past(i_ext_convert_n, 3) && $past(i_ext_convert_n, 4);
   endsequence
   sequence dac_fell_before;
      !$past(i_ext_dac_update_n, 3) && $past(i_ext_dac_update_n, 4);
   endsequence
   sequence hold_recent;
      o_adc_hold || $past(o_adc_hold) || $past(o_adc_hold, 2);
   endsequence
   a_hold_in_seq: assert property (
      o_adc_hold |-> $past(o_acq_active))
      else $error("hold pulse outside a sequence");
   a_gate_blocks: assert property (
      !i_ext_convert_gate_n [*8] |-> !o_adc_hold)
      else $error("hold pulse while gate pin low");
   a_ext_cause: assert property (
      (o_adc_hold && !o_ext_convert_n_oe) |-> conv_fell_before)
      else $error("external hold without a pin fall");
   a_ext_single: assert property (
      (o_adc_hold && !o_ext_convert_n_oe) |=> !o_adc_hold)
      else $error("two holds for one pin pulse");
   a_oe_mode: assert property ((i_wr && i_addr == OFS_CTRL) |=> ##1
      o_ext_convert_n_oe == !$past(i_wdata[CTL_EXT_CONV], 2))
      else $error("pin drive enable does not follow mode");
   a_dac_cause: assert property (
      o_dac_update |-> dac_fell_before)
      else $error("dac update without a pin fall");
   a_dac_single: assert property (o_dac_update |=> !o_dac_update)
      else $error("dac update longer than one cycle");
   a_done_excl: assert property (!(o_acq_active && o_acq_done))
      else $error("active and done together");
   a_done_after: assert property ($rose(o_acq_done) |-> hold_recent)
      else $error("done without a final conversion");
endmodule
bind atc_trigger_ctrl atc_monitor mon_u (.*);
`default_nettype wire

/* verification/atc_src_model.sv */
`timescale 1ns/100ps
`default_nettype none
module atc_src_model (
   input  wire logic i_clock,
   input  wire logic i_pin_oe,
   output logic      o_conv_n,
   output logic      o_conv_en,
   output logic      o_trig_n,
   output logic      o_gate_n,
   output logic      o_dac_n
);
   initial begin
      o_conv_n = 1'b1;
      o_trig_n = 1'b1;
      o_gate_n = 1'b1;
      o_dac_n = 1'b1;
   end
   // never fights the pacing counter on the shared pin
   assign o_conv_en = !i_pin_oe;
   task automatic drive(input int sel, input logic v);
      @(posedge i_clock);
      case (sel)
         0: o_conv_n <= v;
         1: o_trig_n <= v;
         2: o_gate_n <= v;
         default: o_dac_n <= v;
      endcase
   endtask
   task automatic pulse(input int sel);
      drive(sel, 1'b0);
      repeat (5) @(posedge i_clock);
      drive(sel, 1'b1);
      repeat (13) @(posedge i_clock);
   endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import atc_pkg::*;
   logic              i_clock, i_rst, i_wr, i_rd, rd_seen, m_cv, m_en;
   logic              o_ext_convert_n, o_ext_convert_n_oe, o_adc_hold;
   logic              o_dac_update, o_acq_active, o_acq_done;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wdata, o_rdata, exp_q[$];
   wire logic         i_ext_acq_trigger_n, i_ext_convert_gate_n;
   wire logic         i_ext_dac_update_n, i_ext_convert_n;
   int                miscompares, check_count, holds, dacs, n, iv, h0, t;
   int                lows, l0;
   int                seed = 32'hd419;
   realtime           t0, tf, d0, dl;
   // released pin is driven by the source model through m_cv
   assign i_ext_convert_n = o_ext_convert_n_oe ? o_ext_convert_n
                                               : (m_en ? m_cv : 1'b1);
   atc_trigger_ctrl dut_u (.*);
   atc_src_model drv (.i_clock(i_clock), .i_pin_oe(o_ext_convert_n_oe),
      .o_conv_n(m_cv), .o_conv_en(m_en), .o_trig_n(i_ext_acq_trigger_n),
      .o_gate_n(i_ext_convert_gate_n), .o_dac_n(i_ext_dac_update_n));
   initial begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] ex);
      check_count++;
      if (got !== ex) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, ex);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      exp_q.push_back(ex);
      @(posedge i_clock);
      i_rd <= 1'b0;
   endtask
   always @(posedge i_clock) begin
      if (rd_seen === 1'b1) chk(o_rdata, exp_q.pop_front());
      rd_seen <= i_rd;
      if (o_adc_hold === 1'b1) begin
         holds++;
         if (tf == 0) tf = $realtime;
      end
      if (o_dac_update === 1'b1) dacs++;
      if (o_ext_convert_n === 1'b0) lows++;
   end
   task automatic summarize;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // generous against under a thousand cycles of traffic
   initial begin
      #100000;
      miscompares++;
      summarize();
   end
   initial begin
      {i_wr, i_rd} = '0;
      i_addr = ADDR_W'($random(seed));
      i_wdata = DATA_W'($random(seed));
      i_rst = 1'b1;
      repeat (4) @(posedge i_clock);
      i_rst <= 1'b0;
      rd(OFS_CTRL, 16'h0008);
      rd(OFS_SAMPLES, SAMPLES_RST);
      rd(OFS_INTERVAL, INTERVAL_RST);
      rd(OFS_STATUS, 16'h00F1);
      rd(4'hF, DATA_ZERO);
      wr(OFS_CTRL, 16'h000C);
      drv.drive(1, 1'b0);
      repeat (8) @(posedge i_clock);
      rd(OFS_STATUS, 16'h00D1);
      wr(OFS_CMD, 16'h0001);
      rd(OFS_STATUS, 16'h00D1);
      drv.drive(1, 1'b1);
      repeat (8) @(posedge i_clock);
      wr(OFS_CMD, 16'h0001);
      rd(OFS_STATUS, 16'h00F4);
      wr(OFS_CMD, 16'h0002);
      for (int k = 0; k < 3; k++) begin
         n = 1 + $unsigned($random(seed)) % 3;
         // an interval of 10 would put the status read on a pacing pulse
         iv = 11 + $unsigned($random(seed)) % 20;
         wr(OFS_SAMPLES, DATA_W'(n));
         wr(OFS_INTERVAL, DATA_W'(iv));
         wr(OFS_CTRL, k == 1 ? 16'h0000 : 16'h0008);
         if (k == 0) drv.drive(2, 1'b0);
         h0 = holds;
         l0 = lows;
         tf = 0;
         t0 = $realtime;
         drv.pulse(1);
         if (k < 2) begin
            repeat (3 * iv) @(posedge i_clock);
            chk(DATA_W'(holds - h0), DATA_ZERO);
            chk(DATA_W'(o_acq_active), CNT_ONE);
            rd(OFS_STATUS, k == 0 ? 16'h00B4 : 16'h00F4);
            if (k == 0) drv.drive(2, 1'b1);
            else wr(OFS_CTRL, 16'h0008);
         end
         for (t = 0; o_acq_done !== 1'b1 && t < (n + 2) * (iv + 1) + 40; t++)
            @(posedge i_clock);
         repeat (2) @(posedge i_clock);
         chk(DATA_W'(o_acq_done), CNT_ONE);
         chk(DATA_W'(o_acq_active), DATA_ZERO);
         chk(DATA_W'(holds - h0), DATA_W'(n));
         rd(OFS_REMAIN, DATA_ZERO);
         if (k == 2) begin
            // launch and sampling edges add two periods to one interval
            chk(DATA_W'(tf - t0 <= (iv + 3) * CLK_PERIOD_NS), CNT_ONE);
            chk(DATA_W'(lows - l0), DATA_W'(n));
         end
         wr(OFS_CMD, 16'h0002);
      end
      wr(OFS_SAMPLES, 16'h0002);
      wr(OFS_CTRL, 16'h000B);
      repeat (2) @(posedge i_clock);
      chk(DATA_W'(o_ext_convert_n_oe), DATA_ZERO);
      drv.pulse(1);
      h0 = holds;
      drv.pulse(0);
      // pretrigger converts at once; only the countdown waits
      chk(DATA_W'(holds - h0), CNT_ONE);
      rd(OFS_STATUS, 16'h00F2);
      rd(OFS_REMAIN, 16'h0002);
      drv.pulse(1);
      for (int i = 0; i < 2; i++) begin
         h0 = holds;
         tf = 0;
         t0 = $realtime;
         drv.pulse(0);
         chk(DATA_W'(holds - h0), CNT_ONE);
         dl = tf - t0 - 2 * CLK_PERIOD_NS;
         chk(DATA_W'(dl <= HOLD_DELAY_NS), CNT_ONE);
         if (i == 0) begin
            d0 = dl;
         end else begin
            chk(DATA_W'(dl == d0), CNT_ONE);
         end
      end
      rd(OFS_STATUS, 16'h00F8);
      wr(OFS_CMD, 16'h0002);
      for (int m = 0; m < 4; m++) begin
         wr(OFS_CTRL, DATA_W'(m << CTL_UPD_SRC));
         h0 = dacs;
         drv.pulse(3);
         chk(DATA_W'(dacs - h0), DATA_W'(m == 2));
      end
      repeat (4) @(posedge i_clock);
      summarize();
   end
endmodule
`default_nettype wire
